/* File: core/tws_eeprom.sv */
// Two-wire serial EEPROM target: protocol engine, address counter, write timer
//
// Overview of operation
// - SDA falling while SCL high is a start; every command begins with one.
// - SDA rising while SCL high is a stop; after reads it returns to standby.
// - The driver changes SDA only while SCL is low.
// - Eight-bit words; target pulls SDA low on the ninth clock to acknowledge.
// - Standby at power-up and after stop once internal work is done.
// - Densities 2K/4K/8K/16K with 8/9/10/11-bit word addresses.
// - Device word follows each start; top nibble is fixed 1010.
// - 2K: next three bits must equal the three strap inputs.
// - 4K/8K compare two/one strap bits; remaining bits are page bits.
// - Device word LSB high means read, low means write.
// - Match acknowledges; mismatch gives no acknowledge and returns to standby.
// - Byte write: word address, one data byte, stop starts timed write.
// - During the timed write all inputs are ignored, no response.
// - Page write: more bytes before the stop, each acknowledged.
// - Writes increment only in-page address bits, wrapping within the page.
// - Polling: device word acknowledged only after the write has finished.
// - Counter holds last address plus one; 16K reads take page bits from word.
// - Counter persists; reads wrap from last byte to first byte.
// - Current read returns byte at counter; controller NACKs then stops.
// - Random read: dummy write of address, repeated start, then read.
// - Sequential read continues while the controller acknowledges each byte.
// - Inputs sampled on SCL rising, outputs changed after SCL falling.
// - Write guard high blocks all array writes.
// - SDA is only pulled low, otherwise released.
`timescale 1ns/1ps
module tws_eeprom
    import tws_pkg::*;
#(
    parameter logic [1:0]  DENSITY      = tws_pkg::TWS_DEN_16K,
    parameter int unsigned WRITE_CYCLES = tws_pkg::TWS_WRITE_CYC
) (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                ce,
    input  wire tws_pkg::tws_line_t  bus_in,
    input  wire tws_pkg::tws_strap_t strap_in,
    input  wire logic                write_guard,
    output logic                     sda_out,
    output logic                     sda_oe,
    output logic                     standby
);
    import tws_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [TWS_SYNC_N-1:0] sync1_ff;
    logic [TWS_SYNC_N-1:0] sync2_ff;
    wire  [TWS_SYNC_N-1:0] async_in;

    assign async_in = {write_guard, strap_in.lo, strap_in.mid, strap_in.hi, bus_in.sda, bus_in.scl};

    for (genvar gi = 0; gi < TWS_SYNC_N; gi++) begin : g_sync
        always_ff @(posedge clk) begin
            if (rst) begin
                sync1_ff[gi] <= TWS_SYNC_RST[gi];
                sync2_ff[gi] <= TWS_SYNC_RST[gi];
            end else if (ce) begin
                sync1_ff[gi] <= async_in[gi];
                sync2_ff[gi] <= sync1_ff[gi];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Line events

    tws_line_t  line_d_ff;
    tws_line_t  line_s;
    tws_strap_t strap_s;
    tws_evt_t   ev;
    wire        guard_s;

    assign line_s.scl  = sync2_ff[TWS_IX_SCL];
    assign line_s.sda  = sync2_ff[TWS_IX_SDA];
    assign strap_s.hi  = sync2_ff[TWS_IX_HI];
    assign strap_s.mid = sync2_ff[TWS_IX_MID];
    assign strap_s.lo  = sync2_ff[TWS_IX_LO];
    assign guard_s     = sync2_ff[TWS_IX_WG];

    assign ev.rise  = line_s.scl & ~line_d_ff.scl;
    assign ev.fall  = ~line_s.scl & line_d_ff.scl;
    assign ev.start = line_s.scl & line_d_ff.scl & line_d_ff.sda & ~line_s.sda;
    assign ev.stop  = line_s.scl & line_d_ff.scl & ~line_d_ff.sda & line_s.sda;

    always_ff @(posedge clk) begin
        if (rst) begin
            line_d_ff <= tws_line_t'(2'h3);
        end else if (ce) begin
            line_d_ff <= line_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode

    tws_state_t st_ff;
    tws_state_t nxt_st;
    logic [3:0]  cnt_ff,  nxt_cnt;
    logic [7:0]  rx_ff,   nxt_rx;
    logic [7:0]  tx_ff,   nxt_tx;
    logic [7:0]  dev_ff,  nxt_dev;
    logic [10:0] addr_ff, nxt_addr;
    logic        oe_ff,   nxt_oe;
    logic        pend_ff, nxt_pend;
    logic        busy_ff, nxt_busy;
    logic [31:0] bcnt_ff, nxt_bcnt;
    logic        standby_ff;
    logic        mem_we;
    logic [7:0]  mem_rdata;

    wire [10:0] amask    = TWS_ADDR_MASK[DENSITY];
    wire [10:0] pmask    = TWS_PAGE_MASK[DENSITY];
    wire [2:0]  cmask    = TWS_CMP_MASK[DENSITY];
    wire [2:0]  strap_v  = {strap_s.hi, strap_s.mid, strap_s.lo};
    wire        code_ok  = (rx_ff[7:4] == TWS_DEV_CODE);
    wire        strap_ok = (((rx_ff[3:1] ^ strap_v) & cmask) == 3'h0);
    wire        dev_hit  = code_ok & strap_ok;
    wire [10:0] page_src = {dev_ff[3:1], 8'h00} & ~{cmask, 8'h00};
    wire [10:0] waddr    = (page_src | {3'h0, rx_ff}) & amask;
    wire [10:0] addr_rd1 = (addr_ff + TWS_ADDR_ONE) & amask;
    wire [10:0] addr_wr1 = (addr_ff & ~pmask) | ((addr_ff + TWS_ADDR_ONE) & pmask);
    wire [10:0] addr_hi  = addr_ff & ~pmask;
    wire        byte_in  = ev.fall & (cnt_ff == TWS_BIT_BYTE);
    wire        busy_end = (bcnt_ff == 32'(WRITE_CYCLES - 1));
    wire        is_16k   = (DENSITY == TWS_DEN_16K);

    ////////////////////////////////////////////////////////////////////////////
    // Protocol engine

    always_comb begin
        nxt_st   = st_ff;
        nxt_cnt  = cnt_ff;
        nxt_rx   = rx_ff;
        nxt_tx   = tx_ff;
        nxt_dev  = dev_ff;
        nxt_addr = addr_ff;
        nxt_oe   = oe_ff;
        nxt_pend = pend_ff;
        nxt_busy = busy_ff;
        nxt_bcnt = bcnt_ff;
        mem_we   = 1'b0;
        if (busy_ff) begin
            // Self-timed write: everything on the bus is ignored
            nxt_bcnt = busy_end ? 32'h0 : bcnt_ff + 32'h1;
            nxt_busy = ~busy_end;
        end else if (ev.start) begin
            nxt_st  = S_DEV;
            nxt_cnt = TWS_BIT_ZERO;
            nxt_oe  = 1'b0;
        end else if (ev.stop) begin
            nxt_st   = S_IDLE;
            nxt_oe   = 1'b0;
            nxt_busy = pend_ff;
            nxt_pend = 1'b0;
        end else begin
            if (ev.rise && cnt_ff != TWS_BIT_BYTE) begin
                nxt_rx  = {rx_ff[6:0], line_s.sda};
                nxt_cnt = cnt_ff + TWS_BIT_ONE;
            end
            case (st_ff)
                S_DEV: begin
                    if (byte_in) begin
                        nxt_dev = rx_ff;
                        if (dev_hit) begin
                            nxt_oe = 1'b1;
                            nxt_st = S_DEV_ACK;
                            if (rx_ff[0] && is_16k) begin
                                nxt_addr = {rx_ff[3:1], addr_ff[7:0]};
                            end
                        end else begin
                            nxt_st = S_IDLE;
                        end
                    end
                end
                S_DEV_ACK: begin
                    if (ev.fall) begin
                        if (dev_ff[0]) begin
                            nxt_tx   = mem_rdata;
                            nxt_oe   = ~mem_rdata[7];
                            nxt_addr = addr_rd1;
                            nxt_st   = S_RDATA;
                        end else begin
                            nxt_oe  = 1'b0;
                            nxt_st  = S_WADDR;
                        end
                        nxt_cnt = TWS_BIT_ZERO;
                    end
                end
                S_WADDR: begin
                    if (byte_in) begin
                        nxt_addr = waddr;
                        nxt_oe   = 1'b1;
                        nxt_st   = S_WADDR_ACK;
                    end
                end
                S_WADDR_ACK, S_WDATA_ACK: begin
                    if (ev.fall) begin
                        nxt_oe  = 1'b0;
                        nxt_cnt = TWS_BIT_ZERO;
                        nxt_st  = S_WDATA;
                    end
                end
                S_WDATA: begin
                    if (byte_in) begin
                        mem_we   = ~guard_s;
                        nxt_pend = pend_ff | ~guard_s;
                        nxt_addr = addr_wr1;
                        nxt_oe   = 1'b1;
                        nxt_st   = S_WDATA_ACK;
                    end
                end
                S_RDATA: begin
                    if (ev.fall) begin
                        if (cnt_ff == TWS_BIT_BYTE) begin
                            nxt_oe = 1'b0;
                            nxt_st = S_RACK;
                        end else begin
                            nxt_tx = {tx_ff[6:0], 1'b0};
                            nxt_oe = ~tx_ff[6];
                        end
                    end
                end
                S_RACK: begin
                    if (ev.rise) begin
                        nxt_st = line_s.sda ? S_IDLE : S_RNEXT;
                    end
                end
                S_RNEXT: begin
                    if (ev.fall) begin
                        nxt_tx   = mem_rdata;
                        nxt_oe   = ~mem_rdata[7];
                        nxt_addr = addr_rd1;
                        nxt_cnt  = TWS_BIT_ZERO;
                        nxt_st   = S_RDATA;
                    end
                end
                default: begin
                    nxt_st = S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff   <= S_IDLE;
            cnt_ff  <= TWS_BIT_ZERO;
            rx_ff   <= 8'h00;
            tx_ff   <= 8'h00;
            dev_ff  <= 8'h00;
            addr_ff <= 11'h000;
            oe_ff   <= 1'b0;
        end else if (ce) begin
            st_ff   <= nxt_st;
            cnt_ff  <= nxt_cnt;
            rx_ff   <= nxt_rx;
            tx_ff   <= nxt_tx;
            dev_ff  <= nxt_dev;
            addr_ff <= nxt_addr;
            oe_ff   <= nxt_oe;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pend_ff    <= 1'b0;
            busy_ff    <= 1'b0;
            bcnt_ff    <= 32'h0;
            standby_ff <= 1'b1;
        end else if (ce) begin
            pend_ff    <= nxt_pend;
            busy_ff    <= nxt_busy;
            bcnt_ff    <= nxt_bcnt;
            standby_ff <= (nxt_st == S_IDLE) & ~nxt_busy;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = oe_ff;
    assign standby = standby_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Array

    tws_mem #(
        .AW (TWS_MEM_AW),
        .DW (TWS_DW)
    ) u_mem (
        .clk   (clk),
        .ce    (ce),
        .we    (mem_we & ce),
        .addr  (addr_ff),
        .wdata (rx_ff),
        .rdata (mem_rdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    start_to_dev_a: assert property (ce && ev.start && !busy_ff |=> st_ff == S_DEV && cnt_ff == 4'h0)
        else $error("start did not open device word");
    stop_to_idle_a: assert property (ce && ev.stop && !busy_ff |=> st_ff == S_IDLE && !oe_ff)
        else $error("stop did not return to idle");
    drive_low_edge_a: assert property ($changed(oe_ff) && !$past(ev.start) && !$past(ev.stop)
        |-> !$past(line_s.scl))
        else $error("data drive changed while clock high");
    ack_driven_a: assert property (st_ff inside {S_DEV_ACK, S_WADDR_ACK, S_WDATA_ACK} && !ev.fall |-> oe_ff)
        else $error("acknowledge not driven");
    standby_stop_a: assert property (ce && ev.stop && !busy_ff && !pend_ff |=> standby_ff)
        else $error("no standby after stop");
    busy_ignore_a: assert property (busy_ff |-> !oe_ff && st_ff == S_IDLE)
        else $error("response during write cycle");
    nomatch_idle_a: assert property (ce && !busy_ff && !ev.start && !ev.stop && st_ff == S_DEV
        && byte_in && !dev_hit |=> st_ff == S_IDLE && !oe_ff)
        else $error("mismatch not released");
    page_keep_a: assert property (ce && mem_we |=> addr_hi == $past(addr_hi))
        else $error("write left its page");
    guard_block_a: assert property (guard_s |-> !mem_we)
        else $error("write with guard high");
    busy_len_a: assert property (ce && ev.stop && !busy_ff && pend_ff |=> busy_ff && bcnt_ff == 32'h0)
        else $error("write cycle not started at stop");
    open_drain_a: assert property (!sda_out
        && (!oe_ff || st_ff inside {S_DEV_ACK, S_WADDR_ACK, S_WDATA_ACK, S_RDATA}))
        else $error("data line pulled outside acknowledge or read bit");
    read_bit_drive_a: assert property (st_ff == S_RDATA |-> oe_ff == !tx_ff[7])
        else $error("read bit not driven from shift register");
    read_ack_next_a: assert property (ce && !busy_ff && !ev.start && !ev.stop
        && st_ff == S_RACK && ev.rise |=> st_ff == ($past(line_s.sda) ? S_IDLE : S_RNEXT))
        else $error("read acknowledge not followed");

endmodule : tws_eeprom

/* File: core/tws_mem.sv */
// Byte array with synchronous write and registered read
`timescale 1ns/1ps
module tws_mem #(
    parameter int AW = 11,
    parameter int DW = 8
) (
    input  wire logic          clk,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem_ff [2**AW];

    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem_ff[addr] <= wdata;
            end
            rdata <= mem_ff[addr];
        end
    end

endmodule : tws_mem

/* File: core/tws_pkg.sv */
// Shared constants and types for the two-wire serial EEPROM target
package tws_pkg;

    // Clock rate and self-timed write duration
    localparam int TWS_CLK_NS        = 10;
    localparam int TWS_WRITE_TIME_NS = 5000000;
    localparam int TWS_WRITE_CYC     = TWS_WRITE_TIME_NS / TWS_CLK_NS;

    // Widths
    localparam int TWS_MEM_AW = 11;
    localparam int TWS_DW     = 8;
    localparam int TWS_SYNC_N = 6;

    // Positions of the synchronised inputs
    localparam int TWS_IX_SCL = 0;
    localparam int TWS_IX_SDA = 1;
    localparam int TWS_IX_HI  = 2;
    localparam int TWS_IX_MID = 3;
    localparam int TWS_IX_LO  = 4;
    localparam int TWS_IX_WG  = 5;
    localparam logic [5:0] TWS_SYNC_RST = 6'h03;

    // Density selection
    localparam logic [1:0] TWS_DEN_2K  = 2'h0;
    localparam logic [1:0] TWS_DEN_4K  = 2'h1;
    localparam logic [1:0] TWS_DEN_8K  = 2'h2;
    localparam logic [1:0] TWS_DEN_16K = 2'h3;

    // Device address word fields
    localparam logic [3:0] TWS_DEV_CODE  = 4'hA;
    localparam logic [3:0] TWS_BIT_BYTE  = 4'h8;
    localparam logic [3:0] TWS_BIT_ZERO  = 4'h0;
    localparam logic [3:0] TWS_BIT_ONE   = 4'h1;

    // Per-density masks: full address, in-page bits, strap compare bits
    localparam logic [10:0] TWS_ADDR_MASK [4] = '{11'h0FF, 11'h1FF, 11'h3FF, 11'h7FF};
    localparam logic [10:0] TWS_PAGE_MASK [4] = '{11'h007, 11'h00F, 11'h00F, 11'h00F};
    localparam logic [2:0]  TWS_CMP_MASK  [4] = '{3'h7, 3'h6, 3'h4, 3'h0};
    localparam logic [10:0] TWS_ADDR_ONE  = 11'h001;

    typedef struct packed {
        logic scl;
        logic sda;
    } tws_line_t;

    typedef struct packed {
        logic hi;
        logic mid;
        logic lo;
    } tws_strap_t;

    typedef struct packed {
        logic rise;
        logic fall;
        logic start;
        logic stop;
    } tws_evt_t;

    typedef enum logic [3:0] {
        S_IDLE,
        S_DEV,
        S_DEV_ACK,
        S_WADDR,
        S_WADDR_ACK,
        S_WDATA,
        S_WDATA_ACK,
        S_RDATA,
        S_RACK,
        S_RNEXT
    } tws_state_t;

endpackage : tws_pkg

/* File: sim/tws_ctl_model.sv */
// Bus controller model that drives the clock and data lines of the target
`timescale 1ns/1ps
module tws_ctl_model (
    input  wire logic          clk,
    input  wire logic          sda_oe,
    output tws_pkg::tws_line_t bus,
    output logic               res_stb,
    output logic [8:0]         res_val
);
    import tws_pkg::*;
    logic scl_ff;
    logic pull_ff;

    // Open-drain wire with pull-up: low if either party pulls
    assign bus.scl = scl_ff;
    assign bus.sda = ~pull_ff & ~sda_oe;

    initial begin
        scl_ff  = 1'b1;
        pull_ff = 1'b0;
        res_stb = 1'b0;
        res_val = 9'h000;
    end

    ////////////////////////////////////////////////////////////////////////////
    task wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask : wait_n

    // Data set mid low phase, sampled mid high phase
    task bit_cyc(input logic b, output logic r);
        pull_ff = ~b;
        wait_n(4);
        scl_ff = 1'b1;
        wait_n(4);
        r = bus.sda;
        wait_n(4);
        scl_ff = 1'b0;
        wait_n(4);
    endtask : bit_cyc

    task start();
        pull_ff = 1'b0;
        wait_n(4);
        scl_ff = 1'b1;
        wait_n(4);
        pull_ff = 1'b1;
        wait_n(4);
        scl_ff = 1'b0;
        wait_n(4);
    endtask : start

    task stop();
        pull_ff = 1'b1;
        wait_n(4);
        scl_ff = 1'b1;
        wait_n(4);
        pull_ff = 1'b0;
        wait_n(8);
    endtask : stop

    task report(input logic [8:0] v);
        res_val = v;
        res_stb = 1'b1;
        wait_n(1);
        res_stb = 1'b0;
    endtask : report

    // Up to nine clocks until the data line reads high
    task recover();
        logic r;
        r = 1'b0;
        for (int i = 0; i < 9 && !r; i++) begin
            bit_cyc(1'b1, r);
        end
    endtask : recover

    // Byte out MSB first, then the ninth clock reads the acknowledge
    task send_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(b[i], r);
        end
        bit_cyc(1'b1, r);
        report({r, 8'h00});
    endtask : send_byte

    // Byte in, then acknowledge unless last
    task recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, r);
            d[i] = r;
        end
        bit_cyc(last, r);
        report({1'b0, d});
    endtask : recv_byte
endmodule : tws_ctl_model

/* File: sim/tws_eeprom_bench.sv */
// Self-checking bench for the two-wire EEPROM target in 2K density
`timescale 1ns/1ps
module tws_eeprom_bench;
    import tws_pkg::*;
    localparam int WR_CYC = 200;
    logic               clk;
    logic               rst;
    logic               ce;
    logic               guard;
    logic               sda_out;
    logic               sda_oe;
    logic               standby;
    logic               res_stb;
    logic [8:0]         res_val;
    tws_line_t          bus;
    tws_strap_t         strap;
    logic [7:0]         mem [256];
    logic [8:0]         exp_q [$];
    int                 n_fail;
    int                 compares;
    int                 seed;

    tws_eeprom #(.DENSITY(TWS_DEN_2K), .WRITE_CYCLES(WR_CYC)) i_dut (
        .clk(clk), .rst(rst), .ce(ce), .bus_in(bus), .strap_in(strap),
        .write_guard(guard), .sda_out(sda_out), .sda_oe(sda_oe), .standby(standby));
    tws_ctl_model i_ctl (.clk(clk), .sda_oe(sda_oe), .bus(bus), .res_stb(res_stb), .res_val(res_val));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task check(input string what, input logic [8:0] seen, input logic [8:0] expv);
        compares++;
        if (seen !== expv) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, expv, seen);
        end
    endtask : check

    task end_of_test();
        $display("checks %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    // Oldest note against each result the controller reports
    always @(posedge clk) begin
        if (res_stb === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_fail++;
                $display("[FAIL] bus result expected none seen %h", res_val);
            end else begin
                check("bus result", res_val, exp_q.pop_front());
            end
        end
    end

    task wr_byte(input logic [7:0] b, input logic nack);
        exp_q.push_back({nack, 8'h00});
        i_ctl.send_byte(b);
    endtask : wr_byte

    task rd_byte(input logic [7:0] e, input logic last);
        logic [7:0] d;
        exp_q.push_back({1'b0, e});
        i_ctl.recv_byte(last, d);
    endtask : rd_byte

    task dev(input logic rd, input logic ok);
        logic [2:0] s;
        s = ok ? strap : ~strap;
        i_ctl.start();
        wr_byte({TWS_DEV_CODE, s, rd}, ~ok);
    endtask : dev

    task wr_page(input logic [7:0] a, input int n);
        logic [7:0] ix;
        logic [7:0] d;
        dev(1'b0, 1'b1);
        wr_byte(a, 1'b0);
        for (int i = 0; i < n; i++) begin
            ix = {a[7:3], 3'(a[2:0] + i)};
            d = 8'($random(seed));
            if (!guard) mem[ix] = d;
            wr_byte(d, 1'b0);
        end
        i_ctl.stop();
    endtask : wr_page

    task rd_seq(input logic [7:0] a, input int n);
        logic [7:0] ix;
        dev(1'b0, 1'b1);
        wr_byte(a, 1'b0);
        dev(1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            ix = 8'(a + i);
            rd_byte(mem[ix], i == n - 1);
        end
        i_ctl.stop();
    endtask : rd_seq

    task wait_idle();
        for (int i = 0; i < 2000 && standby !== 1'b1; i++) @(negedge clk);
        check("standby after write", {8'h00, standby}, 9'h001);
    endtask : wait_idle

    initial begin
        repeat (40000) @(posedge clk);
        n_fail++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        compares = 0;
        seed = 59525;
        rst = 1'b1;
        ce = 1'b1;
        guard = 1'b0;
        strap = 3'($random(seed));
        repeat (6) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        check("standby at reset", {8'h00, standby}, 9'h001);
        i_ctl.recover();
        wr_page(8'hFA, 10);
        check("standby busy", {8'h00, standby}, 9'h000);
        i_ctl.start();
        wr_byte({TWS_DEV_CODE, strap, 1'b0}, 1'b1);
        i_ctl.stop();
        wait_idle();
        rd_seq(8'hF8, 8);
        $display("test page write wrap done");
        wr_page(8'h00, 2);
        wait_idle();
        @(negedge clk) guard = 1'b1;
        wr_page(8'h00, 2);
        i_ctl.wait_n(4);
        check("standby guarded", {8'h00, standby}, 9'h001);
        @(negedge clk) guard = 1'b0;
        $display("test write guard done");
        rd_seq(8'hFE, 3);
        dev(1'b1, 1'b1);
        rd_byte(mem[1], 1'b1);
        i_ctl.stop();
        $display("test read wrap done");
        dev(1'b0, 1'b0);
        i_ctl.stop();
        check("drive value", {8'h00, sda_out}, 9'h000);
        $display("test mismatch done");
        for (int i = 0; i < 500 && exp_q.size() > 0; i++) @(negedge clk);
        check("pending notes", 9'(exp_q.size()), 9'h000);
        end_of_test();
    end
endmodule : tws_eeprom_bench
